// >>> rms_seq.sv
/*
 * relay mux sequencer: takes relay writes and configuration updates,
 * opens, waits, closes and settles the bank and function relays, gates
 * on the sync input and pulses the sync output.
 * assumes write and cfg strobes are one-cycle pulses on i_sys_clk and
 * i_sync_in is an asynchronous pin.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rms_defs.svh"
module rms_seq (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // board variant
    input wire logic i_reduced,
    // relay write
    input wire logic i_wr,
    input wire logic [3:0] i_wr_chan,
    input wire logic [1:0] i_wr_bank,
    input wire logic [1:0] i_wr_func,
    input wire logic i_wr_sync_in,
    input wire logic i_wr_sync_out,
    // configuration update
    input wire logic i_cfg_wr,
    input wire logic [7:0] i_cfg_mask,
    input wire logic i_cfg_fn_bbm,
    input wire logic [15:0] i_cfg_settle,
    input wire logic [15:0] i_cfg_break,
    input wire logic i_cfg_sin_mode,
    input wire logic i_cfg_sin_pol,
    input wire logic [15:0] i_cfg_strobe_pulse_width,
    input wire logic i_cfg_sout_mode,
    input wire logic i_cfg_skip,
    // status
    input wire logic i_ovr_clr,
    output logic [16:0] o_status,
    // pins
    input wire logic i_sync_in,
    output logic o_sync_out,
    output logic [12:0] o_relay_a,
    output logic [12:0] o_relay_b,
    output logic [3:0] o_relay_d
);
    // ===========================================================
    // timers
    rms_tmr_if ph_if ();
    rms_tmr_if pu_if ();

    rms_timer u_phase (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .t(ph_if.timer)
    );
    rms_timer u_pulse (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .t(pu_if.timer)
    );

    // ===========================================================
    // function relay map, bit 0 is the first function relay
    function automatic logic [3:0] dmap(input logic [1:0] f, input logic [1:0] b);
        logic [3:0] d;
        d = 4'h0;
        unique case (f)
            2'h0, 2'h2: d = b[1] ? 4'h3 : 4'h2;
            2'h1: d = b[1] ? 4'h5 : 4'h4;
            2'h3: d = 4'ha;
        endcase
        return d;
    endfunction : dmap

    function automatic logic [12:0] onehot(input logic [3:0] c);
        logic [12:0] v;
        v = 13'h0001;
        return v << c;
    endfunction : onehot

    // ===========================================================
    // state
    rms_pkg::rms_top_t s_r;
    rms_pkg::rms_top_t s_nxt;
    logic range_ok;
    logic sync_ok;
    logic [3:0] new_d;
    logic [3:0] lim;

    always_comb begin
        s_nxt = s_r;
        ph_if.start = 1'b0;
        ph_if.load = s_r.cfg.brk;
        pu_if.start = 1'b0;
        pu_if.load = s_r.cfg.pw;
        lim = i_reduced ? `RMS_MAX_CH_RED : `RMS_MAX_CH_STD;
        range_ok = (i_wr_chan <= lim) && (i_wr_bank != 2'h0);
        sync_ok = (s_r.sy_lvl == s_r.cfg.sin_pol);
        new_d = (s_r.st == rms_pkg::RMS_IDLE) ? dmap(i_wr_func, i_wr_bank)
                                               : dmap(s_r.func, s_r.bank);

        // sync input: three stages, a change counts when 2 and 3 agree
        s_nxt.sy1 = i_sync_in;
        s_nxt.sy2 = s_r.sy1;
        s_nxt.sy3 = s_r.sy2;
        if (s_r.sy2 == s_r.sy3) begin
            s_nxt.sy_lvl = s_r.sy3;
        end

        // cumulative configuration
        if (i_cfg_wr) begin
            if (i_cfg_mask[`RMS_CM_FN_BBM]) s_nxt.cfg.fn_bbm = i_cfg_fn_bbm;
            if (i_cfg_mask[`RMS_CM_SETTLE]) s_nxt.cfg.settle = i_cfg_settle;
            if (i_cfg_mask[`RMS_CM_BREAK]) s_nxt.cfg.brk = i_cfg_break;
            if (i_cfg_mask[`RMS_CM_SIN_MODE]) s_nxt.cfg.sin_mode = i_cfg_sin_mode;
            if (i_cfg_mask[`RMS_CM_SIN_POL]) s_nxt.cfg.sin_pol = i_cfg_sin_pol;
            if (i_cfg_mask[`RMS_CM_PW]) s_nxt.cfg.pw = i_cfg_strobe_pulse_width;
            if (i_cfg_mask[`RMS_CM_SOUT_MODE]) s_nxt.cfg.sout_mode = i_cfg_sout_mode;
            if (i_cfg_mask[`RMS_CM_SKIP]) s_nxt.cfg.skip = i_cfg_skip;
        end

        // overrun: set wins over clear
        if (i_wr && s_r.st != rms_pkg::RMS_IDLE) begin
            s_nxt.ovr = 1'b1;
        end else if (i_ovr_clr) begin
            s_nxt.ovr = 1'b0;
        end

        // sync output pulse end
        if (pu_if.done) begin
            s_nxt.sync_out = 1'b0;
        end

        unique case (s_r.st)
            rms_pkg::RMS_IDLE: begin
                if (i_wr && range_ok) begin
                    s_nxt.chan = i_wr_chan;
                    s_nxt.bank = i_wr_bank;
                    s_nxt.func = rms_pkg::rms_func_t'(i_wr_func);
                    s_nxt.sout = i_wr_sync_out;
                    if (i_wr_sync_in && s_r.cfg.sin_mode && !s_r.cfg.skip) begin
                        s_nxt.st = rms_pkg::RMS_WAIT;
                    end else begin
                        s_nxt.st = rms_pkg::RMS_BRK;
                    end
                end
            end
            rms_pkg::RMS_WAIT: begin
                if (sync_ok || s_r.cfg.skip) begin
                    s_nxt.st = rms_pkg::RMS_BRK;
                end
            end
            rms_pkg::RMS_BRK: begin
                if (ph_if.done) begin
                    s_nxt.rly_a = s_r.bank[0] ? onehot(s_r.chan) : 13'h0000;
                    s_nxt.rly_b = s_r.bank[1] ? onehot(s_r.chan) : 13'h0000;
                    s_nxt.rly_d = new_d;
                    if (s_r.sout && s_r.cfg.sout_mode) begin
                        s_nxt.sync_out = 1'b1;
                        pu_if.start = 1'b1;
                    end
                    ph_if.start = 1'b1;
                    ph_if.load = s_r.cfg.settle;
                    s_nxt.st = rms_pkg::RMS_SETL;
                end
            end
            rms_pkg::RMS_SETL: begin
                if (ph_if.done) begin
                    s_nxt.st = rms_pkg::RMS_IDLE;
                end
            end
        endcase

        // entering the break: everything opens, function relays maybe kept
        if (s_nxt.st == rms_pkg::RMS_BRK && s_r.st != rms_pkg::RMS_BRK) begin
            s_nxt.rly_a = 13'h0000;
            s_nxt.rly_b = 13'h0000;
            if (s_r.cfg.fn_bbm || s_r.rly_d != new_d) begin
                s_nxt.rly_d = 4'h0;
            end
            ph_if.start = 1'b1;
            ph_if.load = s_r.cfg.brk;
        end

        s_nxt.stat = '0;
        s_nxt.stat[`RMS_ST_SYNC] = s_nxt.sy_lvl;
        s_nxt.stat[`RMS_ST_READY] = (s_nxt.st == rms_pkg::RMS_IDLE);
        s_nxt.stat[`RMS_ST_WAIT] = (s_nxt.st == rms_pkg::RMS_WAIT) ||
                                   (s_nxt.st == rms_pkg::RMS_BRK);
        s_nxt.stat[`RMS_ST_BUSY] = (s_nxt.st != rms_pkg::RMS_IDLE);
        s_nxt.stat[`RMS_ST_OVR] = s_nxt.ovr;
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            s_r <= '0;
            s_r.st <= rms_pkg::RMS_IDLE;
            s_r.stat <= 17'h00002;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_status = s_r.stat;
    assign o_sync_out = s_r.sync_out;
    assign o_relay_a = s_r.rly_a;
    assign o_relay_b = s_r.rly_b;
    assign o_relay_d = s_r.rly_d;

    // ===========================================================
    // checks
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);

    sequence s_closing;
        s_r.st == rms_pkg::RMS_BRK && ph_if.done;
    endsequence
    sequence s_closed;
        s_r.st == rms_pkg::RMS_SETL && $past(s_r.st) == rms_pkg::RMS_BRK;
    endsequence

    property p_open_in_break;
        s_r.st == rms_pkg::RMS_BRK |-> (o_relay_a == 13'h0000 && o_relay_b == 13'h0000 &&
                                        ph_if.busy);
    endproperty
    a_open_in_break: assert property (p_open_in_break) else $error("relay closed in break");

    property p_brk_len;
        (s_r.st == rms_pkg::RMS_IDLE && i_wr && range_ok && !i_wr_sync_in &&
         s_r.cfg.brk == 16'h0003 && !i_cfg_wr)
        |=> s_r.st == rms_pkg::RMS_BRK [*3] ##1 s_r.st == rms_pkg::RMS_SETL;
    endproperty
    a_brk_len: assert property (p_brk_len) else $error("break length wrong");

    property p_keep_d;
        (s_r.st == rms_pkg::RMS_IDLE && i_wr && range_ok && !s_r.cfg.fn_bbm &&
         new_d == s_r.rly_d) |=> o_relay_d == $past(o_relay_d);
    endproperty
    a_keep_d: assert property (p_keep_d) else $error("function relays dropped");

    property p_range;
        (s_r.st == rms_pkg::RMS_IDLE && i_wr && i_wr_chan > lim)
        |=> s_r.st == rms_pkg::RMS_IDLE;
    endproperty
    a_range: assert property (p_range) else $error("bad channel accepted");

    property p_bank_b_v;
        s_closing and (s_r.func == rms_pkg::RMS_F_V && s_r.bank == 2'h2)
        |=> o_relay_d == 4'h3 && o_relay_b == onehot(s_r.chan) && o_relay_a == 13'h0000;
    endproperty
    a_bank_b_v: assert property (p_bank_b_v) else $error("bank B voltage route wrong");

    property p_four_wire;
        s_closing and (s_r.func == rms_pkg::RMS_F_R4 && s_r.bank == 2'h3)
        |=> o_relay_d == 4'ha && o_relay_a == o_relay_b && o_relay_a != 13'h0000;
    endproperty
    a_four_wire: assert property (p_four_wire) else $error("four-wire route wrong");

    property p_pulse_start;
        $rose(o_sync_out) |-> s_closed and s_r.sout && s_r.cfg.sout_mode && pu_if.busy;
    endproperty
    a_pulse_start: assert property (p_pulse_start) else $error("sync pulse misplaced");

    property p_pulse_w2;
        (s_closing and (s_r.sout && s_r.cfg.sout_mode && s_r.cfg.pw == 16'h0002))
        |=> o_sync_out [*2] ##1 !o_sync_out;
    endproperty
    a_pulse_w2: assert property (p_pulse_w2) else $error("sync pulse width wrong");

    property p_gate;
        (s_r.st == rms_pkg::RMS_WAIT && !sync_ok && !s_r.cfg.skip)
        |=> s_r.st == rms_pkg::RMS_WAIT;
    endproperty
    a_gate: assert property (p_gate) else $error("gate released early");

    property p_skip;
        (s_r.st == rms_pkg::RMS_WAIT && s_r.cfg.skip) |=> s_r.st == rms_pkg::RMS_BRK;
    endproperty
    a_skip: assert property (p_skip) else $error("skip did not release");

    property p_ovr;
        (i_wr && s_r.st != rms_pkg::RMS_IDLE)
        |-> o_status[`RMS_ST_BUSY] ##1 o_status[`RMS_ST_OVR];
    endproperty
    a_ovr: assert property (p_ovr) else $error("overrun not flagged");

    property p_ready;
        o_status[`RMS_ST_READY] == (s_r.st == rms_pkg::RMS_IDLE) &&
        o_status[`RMS_ST_WAIT] == (s_r.st inside {rms_pkg::RMS_WAIT, rms_pkg::RMS_BRK});
    endproperty
    a_ready: assert property (p_ready) else $error("status bits wrong");
endmodule : rms_seq
`default_nettype wire

// >>> rms_defs.svh
/*
 * constants for the relay mux sequencer: cfg mask bits, status bits, limits.
 * assumes it is included by bare name from the sequencer files.
 */
`ifndef RMS_DEFS_SVH
`define RMS_DEFS_SVH
// ===========================================================
// timing
`define RMS_CLK_NS 20
`define RMS_PW_1MS_NS 1000000
`define RMS_PW_1MS_CYC (`RMS_PW_1MS_NS / `RMS_CLK_NS)
// ===========================================================
// cfg field mask bits
`define RMS_CM_FN_BBM 0
`define RMS_CM_SETTLE 1
`define RMS_CM_BREAK 2
`define RMS_CM_SIN_MODE 3
`define RMS_CM_SIN_POL 4
`define RMS_CM_PW 5
`define RMS_CM_SOUT_MODE 6
`define RMS_CM_SKIP 7
// ===========================================================
// status bits and limits
`define RMS_ST_SYNC 0
`define RMS_ST_READY 1
`define RMS_ST_WAIT 2
`define RMS_ST_BUSY 3
`define RMS_ST_OVR 16
`define RMS_MAX_CH_STD 4'hc
`define RMS_MAX_CH_RED 4'hb
`endif

// >>> rms_pkg.sv
/*
 * types of the relay mux sequencer.
 * assumes rms_defs.svh for constants.
 */
`default_nettype none
package rms_pkg;
    // ===========================================================
    // sequencer states
    typedef enum logic [3:0] {
        RMS_IDLE = 4'b0001,
        RMS_WAIT = 4'b0010,
        RMS_BRK = 4'b0100,
        RMS_SETL = 4'b1000
    } rms_state_t;
    // meter functions
    typedef enum logic [1:0] {
        RMS_F_V = 2'h0,
        RMS_F_I = 2'h1,
        RMS_F_R2 = 2'h2,
        RMS_F_R4 = 2'h3
    } rms_func_t;
    // ===========================================================
    // configuration
    typedef struct packed {
        logic fn_bbm;
        logic [15:0] settle;
        logic [15:0] brk;
        logic sin_mode;
        logic sin_pol;
        logic [15:0] pw;
        logic sout_mode;
        logic skip;
    } rms_cfg_t;
    // ===========================================================
    // top state
    typedef struct packed {
        rms_state_t st;
        rms_cfg_t cfg;
        logic [3:0] chan;
        logic [1:0] bank;
        rms_func_t func;
        logic sout;
        logic [12:0] rly_a;
        logic [12:0] rly_b;
        logic [3:0] rly_d;
        logic sync_out;
        logic ovr;
        logic sy1;
        logic sy2;
        logic sy3;
        logic sy_lvl;
        logic [16:0] stat;
    } rms_top_t;
    typedef struct packed {
        logic [15:0] cnt;
    } rms_tmr_t;
endpackage : rms_pkg
`default_nettype wire

// >>> rms_tmr_if.sv
/*
 * start/done carrier between the sequencer and a cycle timer.
 * assumes one clock shared by both ends.
 */
`timescale 1ns/1ps
`default_nettype none
interface rms_tmr_if;
    logic start;
    logic [15:0] load;
    logic done;
    logic busy;
    modport owner (output start, output load, input done, input busy);
    modport timer (input start, input load, output done, output busy);
endinterface : rms_tmr_if
`default_nettype wire

// >>> rms_timer.sv
/*
 * down counter: a start loads the count (zero counts as one), done pulses
 * in the last counted cycle.
 * assumes start and load come from logic on i_sys_clk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rms_defs.svh"
module rms_timer (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // control
    rms_tmr_if.timer t
);
    rms_pkg::rms_tmr_t s_r;
    rms_pkg::rms_tmr_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (t.start) begin
            s_nxt.cnt = (t.load == 16'h0000) ? 16'h0001 : t.load;
        end else if (s_r.cnt != 16'h0000) begin
            s_nxt.cnt = s_r.cnt - 16'h0001;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign t.done = (s_r.cnt == 16'h0001);
    assign t.busy = (s_r.cnt != 16'h0000);

    property p_tmr_len;
        @(posedge i_sys_clk) disable iff (i_rst)
        (t.start && t.load == 16'h0003) |=> !t.done ##1 !t.done ##1 t.done;
    endproperty
    a_tmr_len: assert property (p_tmr_len) else $error("timer length wrong");
endmodule : rms_timer
`default_nettype wire

// >>> rms_peer.sv
/*
 * peer board sync source: drives the sync pin high for PW cycles after
 * an armed delay, low at rest.
 * assumes arm is a one-cycle pulse on i_sys_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module rms_peer #(
    parameter int PW = 40
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // control
    input wire logic i_arm,
    input wire logic [15:0] i_delay,
    // pin
    output logic o_sync
);
    // ===========================================================
    // delay, then hold the level
    logic armed_r;
    logic [15:0] wait_r;
    logic [15:0] hold_r;
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            armed_r <= 1'b0;
            wait_r <= 16'h0;
            hold_r <= 16'h0;
        end else if (i_arm) begin
            armed_r <= 1'b1;
            wait_r <= i_delay;
        end else if (armed_r && wait_r == 16'h0) begin
            armed_r <= 1'b0;
            hold_r <= 16'(PW);
        end else if (armed_r) begin
            wait_r <= wait_r - 16'h1;
        end else if (hold_r != 16'h0) begin
            hold_r <= hold_r - 16'h1;
        end
    end
    assign o_sync = (hold_r != 16'h0);
endmodule : rms_peer
`default_nettype wire

// >>> rms_seq_bench.sv
/*
 * self-checking bench of the relay mux sequencer with a peer sync source.
 * assumes rms_seq and rms_peer are compiled before it.
 */
`timescale 1ns/1ps
`default_nettype none
module rms_seq_bench;
    // ===========================================================
    // signals
    logic i_sys_clk, i_rst, i_reduced, i_wr, i_wr_sync_in, i_wr_sync_out, i_cfg_wr;
    logic [3:0] i_wr_chan;
    logic [1:0] i_wr_bank, i_wr_func;
    logic [7:0] i_cfg_mask;
    logic i_cfg_fn_bbm, i_cfg_sin_mode, i_cfg_sin_pol, i_cfg_sout_mode, i_cfg_skip, i_ovr_clr;
    logic [15:0] i_cfg_settle, i_cfg_break, i_cfg_strobe_pulse_width, peer_delay;
    logic [16:0] o_status;
    logic o_sync_out, sync_pin, peer_arm, m_bbm, m_omode;
    logic [12:0] o_relay_a, o_relay_b;
    logic [3:0] o_relay_d, cur_d;
    int m_settle, m_brk, m_pw, n_mismatch, comparisons;

    rms_seq i_dut (.i_sys_clk, .i_rst, .i_reduced, .i_wr, .i_wr_chan, .i_wr_bank, .i_wr_func,
        .i_wr_sync_in, .i_wr_sync_out, .i_cfg_wr, .i_cfg_mask, .i_cfg_fn_bbm, .i_cfg_settle,
        .i_cfg_break, .i_cfg_sin_mode, .i_cfg_sin_pol, .i_cfg_strobe_pulse_width,
        .i_cfg_sout_mode, .i_cfg_skip, .i_ovr_clr, .o_status, .i_sync_in(sync_pin),
        .o_sync_out, .o_relay_a, .o_relay_b, .o_relay_d);
    rms_peer #(.PW(40)) i_peer (.i_sys_clk, .i_rst, .i_arm(peer_arm), .i_delay(peer_delay),
        .o_sync(sync_pin));

    always #10 i_sys_clk = ~i_sys_clk;

    // ===========================================================
    // expectations and checks
    function automatic logic [3:0] dmap(input logic [1:0] f, input logic [1:0] b);
        case (f)
            2'h1: return b[1] ? 4'h5 : 4'h4;
            2'h3: return 4'ha;
            default: return b[1] ? 4'h3 : 4'h2;
        endcase
    endfunction : dmap

    function automatic int eff(input int v);
        return (v == 0) ? 1 : v;
    endfunction : eff

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk

    task automatic print_verdict();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict

    // ===========================================================
    // drivers
    task automatic cfg(input logic [7:0] m, input logic bb, input logic [15:0] st,
        input logic [15:0] br, input logic sm, input logic om, input logic sk);
        {i_cfg_wr, i_cfg_mask, i_cfg_fn_bbm, i_cfg_settle, i_cfg_break} = {1'b1, m, bb, st, br};
        {i_cfg_sin_mode, i_cfg_sin_pol, i_cfg_sout_mode, i_cfg_skip} = {sm, 1'b1, om, sk};
        i_cfg_strobe_pulse_width = st + 16'h2;
        if (m[0]) m_bbm = bb;
        if (m[1]) m_settle = st;
        if (m[2]) m_brk = br;
        if (m[5]) m_pw = st + 16'h2;
        if (m[6]) m_omode = om;
        @(negedge i_sys_clk);
        i_cfg_wr = 1'b0;
    endtask : cfg

    // evt: 1 write while busy, 2 skip at evk, 3 peer armed at evk, 4 gate already open
    task automatic run_wr(input logic [3:0] ch, input logic [1:0] bk, input logic [1:0] fn,
        input logic si, input logic so, input int evk, input int evt);
        logic [12:0] ea;
        logic [12:0] eb;
        logic [3:0] ed;
        logic [3:0] dm;
        int tc = 0;
        int tp = 0;
        int np = 0;
        int tr = 0;
        int b = eff(m_brk);
        int s = eff(m_settle);
        int w = (so && m_omode) ? eff(m_pw) : 0;
        ea = bk[0] ? 13'h1 << ch : 13'h0;
        eb = bk[1] ? 13'h1 << ch : 13'h0;
        ed = dmap(fn, bk);
        dm = (!m_bbm && ed === cur_d) ? cur_d : 4'h0;
        {i_wr, i_wr_chan, i_wr_bank, i_wr_func, i_wr_sync_in, i_wr_sync_out} = {1'b1, ch, bk, fn, si, so};
        for (int k = 1; k < 3000 && (tr == 0 || k <= tc + w); k++) begin
            @(negedge i_sys_clk);
            if (k == 1) i_wr = 1'b0;
            if (evt == 1 && k == 2) {i_wr, i_wr_chan, i_wr_bank} = {1'b1, 4'h0, 2'h1};
            if (evt == 1 && k == 3) i_wr = 1'b0;
            if (evt == 1 && k == 4) chk("overrun", 1, o_status[16]);
            if (evt == 2 && k == evk) {i_cfg_wr, i_cfg_mask, i_cfg_skip} = {1'b1, 8'h80, 1'b1};
            if (evt == 2 && k == evk + 1) i_cfg_wr = 1'b0;
            if (evt == 3) peer_arm = (k == evk);
            if (evt > 1 && k == evk - 1) chk("stall_busy_wait", 3, o_status[3:2]);
            if (evt > 1 && k == evk - 1) chk("stall_closed", 0, tc);
            if (tc == 0 && {o_relay_a, o_relay_b} === {ea, eb}) tc = k;
            else if (tc == 0 && evt < 2) chk("open", dm, {o_relay_a, o_relay_b, o_relay_d});
            if (o_sync_out === 1'b1) np++;
            if (o_sync_out === 1'b1 && tp == 0) tp = k;
            if (tr == 0 && o_status[1] === 1'b1) tr = k;
        end
        if (tr == 0) begin
            chk("ready_seen", 1, 0);
            print_verdict();
        end
        if (evt == 2 || evt == 3) begin
            chk("close_in", 1, tc > evk + b && tc <= evk + b + 20);
        end else begin
            chk("close_at", (evt == 4) ? 2 + b : 1 + b, tc);
        end
        chk("ready_at", tc + s, tr);
        chk("pulse_len", w, np);
        if (w > 0) chk("pulse_at", tc, tp);
        chk("relay_a", ea, o_relay_a);
        chk("relay_b", eb, o_relay_b);
        chk("relay_d", ed, o_relay_d);
        cur_d = ed;
    endtask : run_wr

    task automatic ign(input logic [3:0] ch, input logic [1:0] bk);
        logic [12:0] a0;
        a0 = o_relay_a;
        {i_wr, i_wr_chan, i_wr_bank, i_wr_func} = {1'b1, ch, bk, 2'h0};
        @(negedge i_sys_clk);
        i_wr = 1'b0;
        repeat (3) @(negedge i_sys_clk);
        chk("ignored_status", 32'h2, o_status);
        chk("ignored_relay", a0, o_relay_a);
    endtask : ign

    // ===========================================================
    // sequence
    initial begin
        logic [1:0] f;
        {i_sys_clk, i_rst, i_reduced, i_wr, i_wr_sync_in, i_wr_sync_out} = 6'h10;
        {i_wr_chan, i_wr_bank, i_wr_func, i_cfg_wr, i_cfg_mask, i_ovr_clr} = 18'h0;
        {i_cfg_fn_bbm, i_cfg_sin_mode, i_cfg_sin_pol, i_cfg_sout_mode, i_cfg_skip} = 5'h0;
        {i_cfg_settle, i_cfg_break, i_cfg_strobe_pulse_width, peer_arm} = 49'h0;
        {peer_delay, cur_d, m_bbm, m_omode} = {16'h5, 6'h0};
        {m_settle, m_brk, m_pw, n_mismatch, comparisons} = '0;
        void'($urandom(32'h5ce38539));
        repeat (5) @(negedge i_sys_clk);
        chk("reset_status", 32'h2, o_status);
        chk("reset_pins", 0, {o_relay_a, o_relay_b, o_relay_d, o_sync_out});
        i_rst = 1'b0;
        @(negedge i_sys_clk);
        run_wr(4'h3, 2'h1, 2'h0, 1'b1, 1'b1, 0, 0);
        cfg(8'hff, 1'b0, 16'h3, 16'h3, 1'b0, 1'b1, 1'b0);
        run_wr(4'hc, 2'h2, 2'h0, 1'b0, 1'b1, 0, 0);
        run_wr(4'hc, 2'h3, 2'h3, 1'b0, 1'b0, 0, 0);
        run_wr(4'h5, 2'h3, 2'h3, 1'b0, 1'b1, 0, 0);
        cfg(8'h01, 1'b1, 16'h9, 16'h9, 1'b1, 1'b0, 1'b1);
        run_wr(4'h6, 2'h3, 2'h3, 1'b0, 1'b0, 0, 0);
        run_wr(4'h2, 2'h1, 2'h1, 1'b0, 1'b0, 0, 1);
        i_ovr_clr = 1'b1;
        @(negedge i_sys_clk);
        i_ovr_clr = 1'b0;
        @(negedge i_sys_clk);
        chk("overrun_clear", 0, o_status[16]);
        i_reduced = 1'b1;
        ign(4'hc, 2'h1);
        run_wr(4'hb, 2'h1, 2'h2, 1'b0, 1'b0, 0, 0);
        i_reduced = 1'b0;
        ign(4'hd, 2'h1);
        ign(4'h1, 2'h0);
        cfg(8'h18, 1'b0, 16'h9, 16'h9, 1'b1, 1'b0, 1'b1);
        run_wr(4'h4, 2'h1, 2'h0, 1'b0, 1'b0, 0, 0);
        run_wr(4'h7, 2'h2, 2'h2, 1'b1, 1'b1, 15, 2);
        cfg(8'ha0, 1'b0, 16'h0, 16'h0, 1'b1, 1'b0, 1'b0);
        run_wr(4'h8, 2'h1, 2'h0, 1'b1, 1'b1, 15, 3);
        repeat (2) @(negedge i_sys_clk);
        chk("sync_level_high", 1, o_status[0]);
        repeat (40) @(negedge i_sys_clk);
        chk("sync_level_low", 0, o_status[0]);
        {i_cfg_wr, i_cfg_mask, i_cfg_sin_pol} = {1'b1, 8'h10, 1'b0};
        @(negedge i_sys_clk);
        i_cfg_wr = 1'b0;
        run_wr(4'h9, 2'h1, 2'h0, 1'b1, 1'b1, 0, 4);
        for (int n = 0; n < 12; n++) begin
            cfg(8'($urandom), 1'($urandom), 16'($urandom_range(7)), 16'($urandom_range(7)),
                1'($urandom), 1'($urandom), 1'($urandom));
            f = 2'($urandom_range(3));
            run_wr(4'($urandom_range(12)), (f == 2'h3) ? 2'h3 : 2'($urandom_range(3, 1)), f,
                1'b0, 1'($urandom), 0, 0);
        end
        i_rst = 1'b1;
        @(negedge i_sys_clk);
        chk("rerun_status", 32'h2, o_status);
        chk("rerun_pins", 0, {o_relay_a, o_relay_b, o_relay_d, o_sync_out});
        i_rst = 1'b0;
        print_verdict();
    end
endmodule : rms_seq_bench
`default_nettype wire
